// >>> design/prio_bank.sv
`timescale 1ns/1ps

module prio_bank (
  input  wire logic        CLK_IN,
  input  wire logic        RESET_N_IN,
  input  wire logic [3:0]  ADDR_IN,
  input  wire logic [15:0] WDATA_IN,
  input  wire logic        WR_IN,
  input  wire logic        RD_IN,
  input  wire logic [17:0] IRQ_PENDING_IN,
  output logic      [15:0] RDATA_OUT,
  output logic             REQ_VALID_OUT,
  output logic      [4:0]  REQ_SOURCE_OUT,
  output logic      [2:0]  REQ_LEVEL_OUT,
  output logic      [2:0]  TIMER4_PRIORITY_OUT,
  output logic      [2:0]  COMPARE4_PRIORITY_OUT,
  output logic      [2:0]  COMPARE3_PRIORITY_OUT,
  output logic      [2:0]  UART2_TX_PRIORITY_OUT,
  output logic      [2:0]  UART2_RX_PRIORITY_OUT,
  output logic      [2:0]  EXT_IRQ2_PRIORITY_OUT,
  output logic      [2:0]  TIMER5_PRIORITY_OUT,
  output logic      [2:0]  SPI2_EVENT_PRIORITY_OUT,
  output logic      [2:0]  SPI2_FAULT_PRIORITY_OUT,
  output logic      [2:0]  CAPTURE5_PRIORITY_OUT,
  output logic      [2:0]  CAPTURE4_PRIORITY_OUT,
  output logic      [2:0]  CAPTURE3_PRIORITY_OUT,
  output logic      [2:0]  COMPARE7_PRIORITY_OUT,
  output logic      [2:0]  COMPARE6_PRIORITY_OUT,
  output logic      [2:0]  COMPARE5_PRIORITY_OUT,
  output logic      [2:0]  CAPTURE6_PRIORITY_OUT,
  output logic      [2:0]  PARALLEL_PORT_PRIORITY_OUT,
  output logic      [2:0]  COMPARE8_PRIORITY_OUT
);

  localparam int NSRC = prio_bank_pkg::NUM_SRC;

  logic [2:0]        fld [NSRC];
  logic [NSRC-1:0]   fld_we;
  logic [NSRC*3-1:0] fld_flat;

  logic [15:0] rdata;
  logic [15:0] next_rdata;

  logic        arb_valid;
  logic [4:0]  arb_source;
  logic [2:0]  arb_level;
  logic        req_valid;
  logic [4:0]  req_source;
  logic [2:0]  req_level;
  logic        next_req_valid;
  logic [4:0]  next_req_source;
  logic [2:0]  next_req_level;

  // implemented bits of a register; unmapped addresses have none
  function automatic logic [15:0] reg_mask(input logic [3:0] addr);
    case (addr)
      prio_bank_pkg::OFS_TIMER4_CMP34:
        reg_mask = prio_bank_pkg::MASK_TIMER4_CMP34;
      prio_bank_pkg::OFS_UART2_EXT2_TIMER5:
        reg_mask = prio_bank_pkg::MASK_UART2_EXT2_TIMER5;
      prio_bank_pkg::OFS_SPI2:
        reg_mask = prio_bank_pkg::MASK_SPI2;
      prio_bank_pkg::OFS_CAPTURE345:
        reg_mask = prio_bank_pkg::MASK_CAPTURE345;
      prio_bank_pkg::OFS_CMP567_CAPTURE6:
        reg_mask = prio_bank_pkg::MASK_CMP567_CAPTURE6;
      prio_bank_pkg::OFS_PARPORT_CMP8:
        reg_mask = prio_bank_pkg::MASK_PARPORT_CMP8;
      default:
        reg_mask = 16'h0000;
    endcase
  endfunction : reg_mask

  // does this field live in the addressed register
  function automatic logic field_hit(input int src, input logic [3:0] addr);
    field_hit = (prio_bank_pkg::FIELD_REG[src] == int'(addr));
  endfunction : field_hit

  // gather the fields of one register into a word
  function automatic logic [15:0] read_word(
    input logic [3:0]        addr,
    input logic [NSRC*3-1:0] flat
  );
    logic [15:0] word;
    word = 16'h0000;
    for (int i = 0; i < NSRC; i++) begin
      if (field_hit(i, addr)) begin
        word[prio_bank_pkg::FIELD_LSB[i] +: 3] = flat[i*3 +: 3];
      end
    end
    read_word = word & reg_mask(addr);
  endfunction : read_word

  // field storage, one small register per source
  // unmapped words match no field, so their writes simply fall away
  always_comb begin
    for (int i = 0; i < NSRC; i++) begin
      fld_we[i] = WR_IN && field_hit(i, ADDR_IN);
    end
  end

  for (genvar g = 0; g < NSRC; g++) begin : g_field
    prio_field u_field (
      .clk_in     (CLK_IN),
      .reset_n_in (RESET_N_IN),
      .write_in   (fld_we[g]),
      .wdata_in   (WDATA_IN[prio_bank_pkg::FIELD_LSB[g] +: 3]),
      .value_out  (fld[g])
    );
  end

  always_comb begin
    for (int i = 0; i < NSRC; i++) begin
      fld_flat[i*3 +: 3] = fld[i];
    end
  end

  // read port: data stands only in the cycle after the strobe
  always_comb begin
    next_rdata = 16'h0000;
    if (RD_IN) begin
      next_rdata = read_word(ADDR_IN, fld_flat);
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= next_rdata;
    end
  end

  // arbitration among pending sources
  prio_arbiter u_arbiter (
    .levels_in  (fld_flat),
    .pending_in (IRQ_PENDING_IN),
    .valid_out  (arb_valid),
    .source_out (arb_source),
    .level_out  (arb_level)
  );

  // one cycle of latency keeps the request outputs glitch free
  always_comb begin
    next_req_valid  = arb_valid;
    next_req_source = arb_source;
    next_req_level  = arb_level;
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      req_valid  <= 1'b0;
      req_source <= prio_bank_pkg::SRC_NONE;
      req_level  <= prio_bank_pkg::PRIO_OFF;
    end else begin
      req_valid  <= next_req_valid;
      req_source <= next_req_source;
      req_level  <= next_req_level;
    end
  end

  assign RDATA_OUT                  = rdata;
  assign REQ_VALID_OUT              = req_valid;
  assign REQ_SOURCE_OUT             = req_source;
  assign REQ_LEVEL_OUT              = req_level;
  assign TIMER4_PRIORITY_OUT        = fld[0];
  assign COMPARE4_PRIORITY_OUT      = fld[1];
  assign COMPARE3_PRIORITY_OUT      = fld[2];
  assign UART2_TX_PRIORITY_OUT      = fld[3];
  assign UART2_RX_PRIORITY_OUT      = fld[4];
  assign EXT_IRQ2_PRIORITY_OUT      = fld[5];
  assign TIMER5_PRIORITY_OUT        = fld[6];
  assign SPI2_EVENT_PRIORITY_OUT    = fld[7];
  assign SPI2_FAULT_PRIORITY_OUT    = fld[8];
  assign CAPTURE5_PRIORITY_OUT      = fld[9];
  assign CAPTURE4_PRIORITY_OUT      = fld[10];
  assign CAPTURE3_PRIORITY_OUT      = fld[11];
  assign COMPARE7_PRIORITY_OUT      = fld[12];
  assign COMPARE6_PRIORITY_OUT      = fld[13];
  assign COMPARE5_PRIORITY_OUT      = fld[14];
  assign CAPTURE6_PRIORITY_OUT      = fld[15];
  assign PARALLEL_PORT_PRIORITY_OUT = fld[16];
  assign COMPARE8_PRIORITY_OUT      = fld[17];

  // checking helpers, computed apart from the arbiter
  logic [2:0]      pend_max;
  logic [NSRC-1:0] top_pend;
  logic            all_reset;

  always_comb begin
    pend_max  = prio_bank_pkg::PRIO_OFF;
    top_pend  = '0;
    all_reset = 1'b1;
    for (int i = 0; i < NSRC; i++) begin
      if (IRQ_PENDING_IN[i] && fld[i] > pend_max) begin
        pend_max = fld[i];
      end
      top_pend[i] = IRQ_PENDING_IN[i] && (fld[i] == prio_bank_pkg::PRIO_MAX);
      if (fld[i] != prio_bank_pkg::FIELD_RESET) begin
        all_reset = 1'b0;
      end
    end
  end

  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RESET_N_IN);

  chk_reset_value: assert property (
    $rose(RESET_N_IN) |-> all_reset && !REQ_VALID_OUT
  ) else $error("fields not at priority four after reset");

  chk_top_level: assert property (
    (|top_pend) |=> REQ_VALID_OUT && REQ_LEVEL_OUT == prio_bank_pkg::PRIO_MAX
  ) else $error("pending level seven source not granted at seven");

  chk_lowest_level: assert property (
    (pend_max == prio_bank_pkg::PRIO_MIN)
      |=> REQ_VALID_OUT && REQ_LEVEL_OUT == prio_bank_pkg::PRIO_MIN
  ) else $error("lone level one source not granted at one");

  chk_disabled_silent: assert property (
    (pend_max == prio_bank_pkg::PRIO_OFF) |=> !REQ_VALID_OUT
  ) else $error("request raised with no enabled pending source");

  chk_max_wins: assert property (
    REQ_VALID_OUT |-> REQ_LEVEL_OUT == $past(pend_max)
      && 1'($past(IRQ_PENDING_IN) >> REQ_SOURCE_OUT)
      && 3'($past(fld_flat) >> (3 * REQ_SOURCE_OUT)) == REQ_LEVEL_OUT
  ) else $error("granted source is not the highest pending level");

  chk_reserved_zero: assert property (
    RD_IN |=> (RDATA_OUT & ~reg_mask($past(ADDR_IN))) == 16'h0000
  ) else $error("unimplemented bits read as nonzero");

  chk_read_only_once: assert property (
    !RD_IN |=> RDATA_OUT == 16'h0000
  ) else $error("read data present without a read strobe");

  chk_write_readback: assert property (
    WR_IN ##1 (RD_IN && ADDR_IN == $past(ADDR_IN))
      |=> RDATA_OUT == ($past(WDATA_IN, 2) & reg_mask($past(ADDR_IN)))
  ) else $error("written value not read back");

  chk_reg0_layout: assert property (
    WR_IN && ADDR_IN == prio_bank_pkg::OFS_TIMER4_CMP34
      |=> TIMER4_PRIORITY_OUT == $past(WDATA_IN[14:12])
      && COMPARE4_PRIORITY_OUT == $past(WDATA_IN[10:8])
      && COMPARE3_PRIORITY_OUT == $past(WDATA_IN[6:4])
  ) else $error("register 0 field placement wrong");

  chk_reg1_layout: assert property (
    WR_IN && ADDR_IN == prio_bank_pkg::OFS_UART2_EXT2_TIMER5
      |=> UART2_TX_PRIORITY_OUT == $past(WDATA_IN[14:12])
      && UART2_RX_PRIORITY_OUT == $past(WDATA_IN[10:8])
      && EXT_IRQ2_PRIORITY_OUT == $past(WDATA_IN[6:4])
      && TIMER5_PRIORITY_OUT == $past(WDATA_IN[2:0])
  ) else $error("register 1 field placement wrong");

  chk_reg2_layout: assert property (
    WR_IN && ADDR_IN == prio_bank_pkg::OFS_SPI2
      |=> SPI2_EVENT_PRIORITY_OUT == $past(WDATA_IN[6:4])
      && SPI2_FAULT_PRIORITY_OUT == $past(WDATA_IN[2:0])
  ) else $error("register 2 field placement wrong");

  chk_reg3_layout: assert property (
    WR_IN && ADDR_IN == prio_bank_pkg::OFS_CAPTURE345
      |=> CAPTURE5_PRIORITY_OUT == $past(WDATA_IN[14:12])
      && CAPTURE4_PRIORITY_OUT == $past(WDATA_IN[10:8])
      && CAPTURE3_PRIORITY_OUT == $past(WDATA_IN[6:4])
  ) else $error("register 3 field placement wrong");

  chk_reg4_layout: assert property (
    WR_IN && ADDR_IN == prio_bank_pkg::OFS_CMP567_CAPTURE6
      |=> COMPARE7_PRIORITY_OUT == $past(WDATA_IN[14:12])
      && COMPARE6_PRIORITY_OUT == $past(WDATA_IN[10:8])
      && COMPARE5_PRIORITY_OUT == $past(WDATA_IN[6:4])
      && CAPTURE6_PRIORITY_OUT == $past(WDATA_IN[2:0])
  ) else $error("register 4 field placement wrong");

  chk_reg5_layout: assert property (
    WR_IN && ADDR_IN == prio_bank_pkg::OFS_PARPORT_CMP8
      |=> PARALLEL_PORT_PRIORITY_OUT == $past(WDATA_IN[6:4])
      && COMPARE8_PRIORITY_OUT == $past(WDATA_IN[2:0])
  ) else $error("register 5 field placement wrong");

  chk_fields_hold: assert property (
    !WR_IN |=> $stable(fld_flat)
  ) else $error("field changed without a write");

  chk_unmapped_read: assert property (
    RD_IN && ADDR_IN > prio_bank_pkg::OFS_PARPORT_CMP8
      |=> RDATA_OUT == 16'h0000
  ) else $error("unmapped word read as nonzero");

  chk_unmapped_write: assert property (
    WR_IN && ADDR_IN > prio_bank_pkg::OFS_PARPORT_CMP8
      |=> $stable(fld_flat)
  ) else $error("write to unmapped word changed a field");

  chk_idle_encoding: assert property (
    !REQ_VALID_OUT |-> REQ_SOURCE_OUT == prio_bank_pkg::SRC_NONE
      && REQ_LEVEL_OUT == prio_bank_pkg::PRIO_OFF
  ) else $error("idle request outputs not at their none codes");

  chk_grant_enabled: assert property (
    REQ_VALID_OUT |-> REQ_LEVEL_OUT != prio_bank_pkg::PRIO_OFF
      && int'(REQ_SOURCE_OUT) < NSRC
  ) else $error("grant carries a disabled level or a bad source");

  chk_reset_outputs: assert property (
    $rose(RESET_N_IN) |-> RDATA_OUT == 16'h0000
      && REQ_SOURCE_OUT == prio_bank_pkg::SRC_NONE
      && REQ_LEVEL_OUT == prio_bank_pkg::PRIO_OFF
  ) else $error("read or request outputs not idle after reset");

  cov_grant_top: cover property (
    REQ_VALID_OUT && REQ_LEVEL_OUT == prio_bank_pkg::PRIO_MAX
  );

  cov_grant_low: cover property (
    REQ_VALID_OUT && REQ_LEVEL_OUT == prio_bank_pkg::PRIO_MIN
  );

  cov_write_then_read: cover property (
    WR_IN ##1 RD_IN
  );

  cov_disable_source: cover property (
    WR_IN && WDATA_IN == 16'h0000 ##1 (|IRQ_PENDING_IN) ##1 !REQ_VALID_OUT
  );

  cov_unmapped_write: cover property (
    WR_IN && ADDR_IN > prio_bank_pkg::OFS_PARPORT_CMP8
  );

endmodule : prio_bank

// >>> design/prio_bank_pkg.sv
package prio_bank_pkg;

  localparam int NUM_SRC = 18;
  localparam int NUM_REG = 6;
  localparam int DATA_W  = 16;
  localparam int ADDR_W  = 4;
  localparam int FIELD_W = 3;
  localparam int SRC_W   = 5;

  // word index on the register port
  localparam logic [3:0] OFS_TIMER4_CMP34       = 4'h0;
  localparam logic [3:0] OFS_UART2_EXT2_TIMER5  = 4'h1;
  localparam logic [3:0] OFS_SPI2               = 4'h2;
  localparam logic [3:0] OFS_CAPTURE345         = 4'h3;
  localparam logic [3:0] OFS_CMP567_CAPTURE6    = 4'h4;
  localparam logic [3:0] OFS_PARPORT_CMP8       = 4'h5;

  // implemented bits of each register
  localparam logic [15:0] MASK_TIMER4_CMP34      = 16'h7770;
  localparam logic [15:0] MASK_UART2_EXT2_TIMER5 = 16'h7777;
  localparam logic [15:0] MASK_SPI2              = 16'h0077;
  localparam logic [15:0] MASK_CAPTURE345        = 16'h7770;
  localparam logic [15:0] MASK_CMP567_CAPTURE6   = 16'h7777;
  localparam logic [15:0] MASK_PARPORT_CMP8      = 16'h0077;

  localparam logic [2:0] FIELD_RESET = 3'h4;
  localparam logic [2:0] PRIO_OFF    = 3'h0;
  localparam logic [2:0] PRIO_MIN    = 3'h1;
  localparam logic [2:0] PRIO_MAX    = 3'h7;

  localparam logic [4:0] SRC_NONE = 5'h1f;

  // source order: timer4, cmp4, cmp3, uart2 tx, uart2 rx, ext2, timer5,
  // spi2 event, spi2 fault, cap5, cap4, cap3, cmp7, cmp6, cmp5, cap6,
  // parallel port, cmp8
  localparam int FIELD_REG [NUM_SRC] =
    '{0, 0, 0, 1, 1, 1, 1, 2, 2, 3, 3, 3, 4, 4, 4, 4, 5, 5};
  localparam int FIELD_LSB [NUM_SRC] =
    '{12, 8, 4, 12, 8, 4, 0, 4, 0, 12, 8, 4, 12, 8, 4, 0, 4, 0};

endpackage : prio_bank_pkg

// >>> design/prio_field.sv
`timescale 1ns/1ps

module prio_field (
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       write_in,
  input  wire logic [2:0] wdata_in,
  output logic      [2:0] value_out
);

  logic [2:0] value;
  logic [2:0] next_value;

  always_comb begin
    next_value = value;
    if (write_in) begin
      next_value = wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      value <= prio_bank_pkg::FIELD_RESET;
    end else begin
      value <= next_value;
    end
  end

  assign value_out = value;

endmodule : prio_field

// >>> design/prio_arbiter.sv
`timescale 1ns/1ps

module prio_arbiter (
  input  wire logic [prio_bank_pkg::NUM_SRC*3-1:0] levels_in,
  input  wire logic [prio_bank_pkg::NUM_SRC-1:0]   pending_in,
  output logic                                     valid_out,
  output logic      [4:0]                          source_out,
  output logic      [2:0]                          level_out
);

  // strict greater-than: on a tie the lower source index keeps the grant,
  // and a level of zero can never beat the starting value
  always_comb begin
    valid_out  = 1'b0;
    source_out = prio_bank_pkg::SRC_NONE;
    level_out  = prio_bank_pkg::PRIO_OFF;
    for (int i = 0; i < prio_bank_pkg::NUM_SRC; i++) begin
      if (pending_in[i] && (levels_in[i*3 +: 3] > level_out)) begin
        valid_out  = 1'b1;
        source_out = 5'(i);
        level_out  = levels_in[i*3 +: 3];
      end
    end
  end

endmodule : prio_arbiter

// >>> testbench/irq_src_model.sv
`timescale 1ns/1ps

module irq_src_model (
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  input  wire logic [17:0] raise_in,
  output logic      [17:0] pending_out
);
  // sources hold their flag as a level; one flop of delay like a real peer
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      pending_out <= 18'h00000;
    end else begin
      pending_out <= raise_in;
    end
  end
endmodule : irq_src_model

// >>> testbench/prio_bank_test.sv
`timescale 1ns/1ps

module prio_bank_test;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [17:0] want = 18'h00000;
  logic [17:0] pending;
  logic [15:0] rdata;
  logic        req_valid;
  logic [4:0]  req_src;
  logic [2:0]  req_lvl;
  wire  [53:0] fld;
  logic [15:0] shadow [6];
  logic [15:0] d;
  logic [3:0]  a;
  int          miscompares = 0;
  int          checks_done = 0;

  always #12.5 clk = ~clk;

  irq_src_model u_src (
    .clk_in      (clk),
    .reset_n_in  (rst_n),
    .raise_in    (want),
    .pending_out (pending)
  );

  prio_bank u_dut (
    .CLK_IN                     (clk),
    .RESET_N_IN                 (rst_n),
    .ADDR_IN                    (addr),
    .WDATA_IN                   (wdata),
    .WR_IN                      (wr),
    .RD_IN                      (rd),
    .IRQ_PENDING_IN             (pending),
    .RDATA_OUT                  (rdata),
    .REQ_VALID_OUT              (req_valid),
    .REQ_SOURCE_OUT             (req_src),
    .REQ_LEVEL_OUT              (req_lvl),
    .TIMER4_PRIORITY_OUT        (fld[2:0]),
    .COMPARE4_PRIORITY_OUT      (fld[5:3]),
    .COMPARE3_PRIORITY_OUT      (fld[8:6]),
    .UART2_TX_PRIORITY_OUT      (fld[11:9]),
    .UART2_RX_PRIORITY_OUT      (fld[14:12]),
    .EXT_IRQ2_PRIORITY_OUT      (fld[17:15]),
    .TIMER5_PRIORITY_OUT        (fld[20:18]),
    .SPI2_EVENT_PRIORITY_OUT    (fld[23:21]),
    .SPI2_FAULT_PRIORITY_OUT    (fld[26:24]),
    .CAPTURE5_PRIORITY_OUT      (fld[29:27]),
    .CAPTURE4_PRIORITY_OUT      (fld[32:30]),
    .CAPTURE3_PRIORITY_OUT      (fld[35:33]),
    .COMPARE7_PRIORITY_OUT      (fld[38:36]),
    .COMPARE6_PRIORITY_OUT      (fld[41:39]),
    .COMPARE5_PRIORITY_OUT      (fld[44:42]),
    .CAPTURE6_PRIORITY_OUT      (fld[47:45]),
    .PARALLEL_PORT_PRIORITY_OUT (fld[50:48]),
    .COMPARE8_PRIORITY_OUT      (fld[53:51])
  );

  function automatic logic [15:0] mask_of(input logic [3:0] r);
    case (r)
      4'h0: return prio_bank_pkg::MASK_TIMER4_CMP34;
      4'h1: return prio_bank_pkg::MASK_UART2_EXT2_TIMER5;
      4'h2: return prio_bank_pkg::MASK_SPI2;
      4'h3: return prio_bank_pkg::MASK_CAPTURE345;
      4'h4: return prio_bank_pkg::MASK_CMP567_CAPTURE6;
      4'h5: return prio_bank_pkg::MASK_PARPORT_CMP8;
      default: return 16'h0000;
    endcase
  endfunction : mask_of

  function automatic logic [53:0] lv_of();
    logic [53:0] lv;
    for (int i = 0; i < 18; i++) begin
      lv[3*i+:3] = shadow[prio_bank_pkg::FIELD_REG[i]]
                         [prio_bank_pkg::FIELD_LSB[i]+:3];
    end
    return lv;
  endfunction : lv_of

  // zero field never wins; strict compare keeps the lowest index on a tie
  function automatic logic [8:0] arb(input logic [53:0] lv,
                                     input logic [17:0] p);
    logic [2:0] best;
    logic [4:0] src;
    best = 3'h0;
    src  = 5'h1f;
    for (int i = 0; i < 18; i++) begin
      if (p[i] && lv[3*i+:3] > best) begin
        best = lv[3*i+:3];
        src  = 5'(i);
      end
    end
    return {best != 3'h0, src, best};
  endfunction : arb

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  task automatic wr_reg(input logic [3:0] r, input logic [15:0] v);
    wr    <= 1'b1;
    rd    <= 1'b0;
    addr  <= r;
    wdata <= v;
    if (r < 4'h6) shadow[r] = v & mask_of(r);
    @(posedge clk);
  endtask : wr_reg

  task automatic rd_reg(input logic [3:0] r);
    wr   <= 1'b0;
    rd   <= 1'b1;
    addr <= r;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    check(rdata, (r < 4'h6) ? shadow[r] : 16'h0000);
    @(posedge clk);
  endtask : rd_reg

  task automatic check_fields();
    logic [53:0] x;
    x = lv_of();
    @(negedge clk);
    for (int i = 0; i < 18; i++) begin
      check(16'(fld[3*i+:3]), 16'(x[3*i+:3]));
    end
    @(posedge clk);
  endtask : check_fields

  task automatic check_req(input logic [17:0] p);
    logic [8:0] e;
    wr   <= 1'b0;
    rd   <= 1'b0;
    want <= p;
    e = arb(lv_of(), p);
    repeat (3) @(posedge clk);
    @(negedge clk);
    check(16'({req_valid, req_src, req_lvl}), 16'(e));
    @(posedge clk);
  endtask : check_req

  task automatic reset_shadow();
    for (int r = 0; r < 6; r++) begin
      shadow[r] = {4{1'b0, prio_bank_pkg::FIELD_RESET}} & mask_of(4'(r));
    end
  endtask : reset_shadow

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_sim();
  end

  initial begin
    void'($urandom(27));
    reset_shadow();
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int r = 0; r < 16; r++) rd_reg(4'(r));
    check_fields();
    check_req(18'h00000);
    $display("test reset values done");
    for (int n = 0; n < 60; n++) begin
      a = 4'($urandom_range(0, 15));
      d = 16'($urandom);
      wr_reg(a, d);
      rd_reg(a);
      check_fields();
      check_req(18'($urandom));
    end
    $display("test random access done");
    // corner cases: all disabled, lone level one, level seven, tie
    for (int r = 0; r < 6; r++) wr_reg(4'(r), 16'h0000);
    check_req(18'h3ffff);
    wr_reg(4'h2, 16'h0001);
    check_req(18'h3ffff);
    wr_reg(4'h5, 16'h0060);
    wr_reg(4'h4, 16'h0007);
    check_req(18'h3ffff);
    wr_reg(4'h0, 16'hffff);
    rd_reg(4'h0);
    check_req(18'h3ffff);
    for (int v = 1; v < 8; v++) begin
      wr_reg(4'h1, {4{1'b0, 3'(v)}});
      check_req(18'h00078);
    end
    $display("test arbitration corners done");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    reset_shadow();
    @(posedge clk);
    check_fields();
    rd_reg(4'h3);
    check_req(18'h00078);
    $display("test second reset done");
    end_sim();
  end
endmodule : prio_bank_test
